//--- hdl/tyag_yellow_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tyag_yellow_gen
  import tyag_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_bit_valid,
  input  wire logic        tx_data_in,
  input  wire logic        tx_ds0_bit2,
  input  wire logic        tx_ybit_slot,
  input  wire logic        tx_dl_slot,
  output logic             tx_bit_valid_out,
  output logic             tx_data_out,
  output logic             alarm_active
);

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLDOFF_CYCLES - 1);

  logic [7:0]        ctrl_q, ctrl_d;
  logic [1:0]        frame_q, frame_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  tyag_state_e       st_q, st_d;
  logic [3:0]        idx_q, idx_d;
  logic [7:0]        cnt_q, cnt_d;
  logic [HOLD_W-1:0] hold_q, hold_d;
  logic              en_prev_q;
  logic              tx_q, tx_d;
  logic              txv_q;
  logic              act_q, act_d;

  logic        en, enf, cfg_on, esf, dl_tick, pat_done, en_rise, sending, wr, hit;
  logic [1:0]  fmt;
  logic [15:0] pat;
  logic [31:0] stat;

  // Decoded controls; format 10 has no defined insertion under the rule.
  assign en       = ctrl_q[CTRL_EN_BIT];
  assign enf      = ctrl_q[CTRL_ENF_BIT];
  assign fmt      = ctrl_q[CTRL_FMT_LSB+1:CTRL_FMT_LSB];
  assign cfg_on   = enf && (fmt != FMT_OFF) && (fmt != FMT_RSV);
  assign esf      = (frame_q == MODE_ESF);
  assign sending  = (st_q == ST_SEND);
  assign dl_tick  = tx_bit_valid && tx_dl_slot;
  assign pat_done = sending && esf && dl_tick && (idx_q == 4'hF);
  assign en_rise  = en && !en_prev_q;
  assign pat      = (fmt == FMT_ONES) ? PAT_ONES : PAT_STD;
  assign wr       = psel && penable && pready_q && pwrite;
  assign hit      = (paddr == ADDR_CTRL) || (paddr == ADDR_FRAME) || (paddr == ADDR_STAT);

  always_comb begin
    stat                = 32'h0000_0000;
    stat[STAT_SEND_BIT] = sending;
    stat[STAT_HOLD_BIT] = (st_q == ST_HOLD);
    stat[STAT_CNT_LSB+7:STAT_CNT_LSB] = cnt_q;
  end

  // APB slave: one wait state, so pready comes from a flip-flop and data is ready with it.
  always_comb begin
    ctrl_d    = ctrl_q;
    frame_d   = frame_q;
    pready_d  = psel && penable && !pready_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      pslverr_d = !hit;
      unique case (paddr)
        ADDR_CTRL:  prdata_d = {24'h00_0000, ctrl_q};
        ADDR_FRAME: prdata_d = {30'h0000_0000, frame_q};
        ADDR_STAT:  prdata_d = stat;
        default:    prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata[7:0] & CTRL_MASK;
    end
    if (wr && paddr == ADDR_FRAME) begin
      frame_d = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      frame_q   <= FRAME_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      frame_q   <= frame_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Alarm sequencer. In ESF, ending by enable waits for the 255th pattern; once 255 are counted, clearing enable ends it at once, mid-pattern or not.
  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    cnt_d  = cnt_q;
    hold_d = hold_q;
    unique case (st_q)
      ST_IDLE: begin
        if (cfg_on && en) begin
          st_d  = ST_SEND;
          idx_d = 4'h0;
          cnt_d = 8'h00;
        end
      end
      ST_SEND: begin
        if (esf && dl_tick) begin
          idx_d = 4'(idx_q + 4'h1);
        end
        if (pat_done && cnt_q != PAT_TARGET) begin
          cnt_d = 8'(cnt_q + 8'h01);
        end
        if (en_rise) begin
          cnt_d = 8'h00;
        end
        if (!cfg_on) begin
          st_d   = ST_HOLD;
          hold_d = '0;
        end else if (esf) begin
          if (!en && cnt_q == PAT_TARGET) begin
            st_d   = ST_HOLD;
            hold_d = '0;
          end
        end else if (!en) begin
          st_d   = ST_HOLD;
          hold_d = '0;
        end
      end
      ST_HOLD: begin
        if (hold_q == HOLD_LAST) begin
          st_d = ST_IDLE;
        end else begin
          hold_d = HOLD_W'(hold_q + 1'b1);
        end
      end
    endcase
    act_d = (st_d == ST_SEND);
  end

  // Bit insertion; the stream is delayed one clock so the output leaves a flip-flop.
  always_comb begin
    tx_d = tx_data_in;
    if (sending) begin
      unique case (frame_q)
        MODE_SF, MODE_N: if (tx_ds0_bit2) tx_d = 1'b0;
        MODE_DMX:        if (tx_ybit_slot) tx_d = 1'b0;
        MODE_ESF:        if (tx_dl_slot) tx_d = pat[~idx_q];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ST_IDLE;
      idx_q     <= 4'h0;
      cnt_q     <= 8'h00;
      hold_q    <= '0;
      en_prev_q <= 1'b0;
      tx_q      <= 1'b0;
      txv_q     <= 1'b0;
      act_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      cnt_q     <= cnt_d;
      hold_q    <= hold_d;
      en_prev_q <= en;
      tx_q      <= tx_d;
      txv_q     <= tx_bit_valid;
      act_q     <= act_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign tx_data_out      = tx_q;
  assign tx_bit_valid_out = txv_q;
  assign alarm_active     = act_q;

  // Checks on the alarm behaviour.
  AST_FMT_OFF_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
    (enf && fmt == FMT_OFF && !sending) |=> (tx_data_out == $past(tx_data_in)))
    else $error("Alarm inserted while format select is off.");

  AST_DS0_BIT2: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && (frame_q == MODE_SF || frame_q == MODE_N) && tx_ds0_bit2) |=> !tx_data_out)
    else $error("DS0 bit 2 not forced low during alarm.");

  AST_YBIT: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && frame_q == MODE_DMX && tx_ybit_slot) |=> !tx_data_out)
    else $error("Y-bit not forced low during alarm.");

  AST_ESF_STD_PAT: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && esf && tx_dl_slot && fmt == FMT_STD) |=> (tx_data_out == !$past(idx_q[3])))
    else $error("Wrong standard pattern bit on data link.");

  AST_ESF_ONES_PAT: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && esf && tx_dl_slot && fmt == FMT_ONES) |=> tx_data_out)
    else $error("Ones pattern bit not sent on data link.");

  AST_MIN_PATTERNS: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && cfg_on && esf && cnt_q != PAT_TARGET) |=> sending)
    else $error("ESF alarm ended before 255 patterns.");

  AST_HELD_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && cfg_on && esf && en) |=> sending)
    else $error("ESF alarm ended while enable still high.");

  AST_RESTART_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && en_rise) |=> (cnt_q == 8'h00))
    else $error("New enable pulse did not clear the pattern counter.");

  AST_HOLDOFF: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD && hold_q != HOLD_LAST) |=> (st_q == ST_HOLD && hold_q == $past(hold_q) + 1'b1))
    else $error("Alarm spacing interval cut short.");

  AST_PAT_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (pat_done && !en_rise && cnt_q != PAT_TARGET) |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("Pattern counter did not step at pattern end.");

  AST_NO_RULE_NO_START: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && !enf) |=> !sending)
    else $error("Alarm started with the rule not enforced.");

  // Checks on sequencing, stream pass-through and the register port.
  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held for more than one cycle.");

  AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && paddr == ADDR_CTRL) |=> (en == $past(pwdata[CTRL_EN_BIT])))
    else $error("Send enable did not follow the control write.");

  AST_IDLE_START: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && cfg_on && en) |=> sending)
    else $error("Alarm did not start with enable set under the rule.");

  AST_LINE_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && !esf && !en) |=> !sending)
    else $error("Framed alarm went on after enable was cleared.");

  AST_CFG_OFF_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && !cfg_on) |=> !sending)
    else $error("Alarm went on with format select off.");

  AST_ACTIVE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_active == sending))
    else $error("Alarm active output disagrees with the sequencer.");

  AST_ESF_END: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && esf && cfg_on && !en && cnt_q == PAT_TARGET) |=> (st_q == ST_HOLD))
    else $error("ESF alarm did not end after 255 patterns.");

  AST_IDX_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && esf && dl_tick) |=> (idx_q == $past(idx_q) + 4'h1))
    else $error("Pattern bit index did not step on a data link bit.");

  AST_HOLD_NO_SEND: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD) |=> (st_q != ST_SEND))
    else $error("Alarm restarted straight out of the spacing interval.");

  AST_HOLD_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD && !$past(st_q == ST_HOLD)) |-> (hold_q == '0))
    else $error("Spacing interval did not start from zero.");

  AST_IDLE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    !sending |=> (tx_data_out == $past(tx_data_in)))
    else $error("Stream altered while no alarm was being sent.");

  AST_ESF_DL_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (sending && esf && !tx_dl_slot) |=> (tx_data_out == $past(tx_data_in)))
    else $error("ESF alarm touched a bit outside the data link.");

endmodule : tyag_yellow_gen
`default_nettype wire

//--- include/tyag_pkg.sv
package tyag_pkg;
  // Register byte addresses on the APB.
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_FRAME = 12'h004;
  localparam logic [11:0] ADDR_STAT  = 12'h008;
  // Control register field positions, writable mask and reset value.
  localparam int          CTRL_FMT_LSB = 4;
  localparam int          CTRL_EN_BIT  = 6;
  localparam int          CTRL_ENF_BIT = 7;
  localparam logic [7:0]  CTRL_MASK    = 8'hF0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [1:0]  FRAME_RESET  = 2'h0;
  // Status register field positions.
  localparam int          STAT_SEND_BIT = 0;
  localparam int          STAT_HOLD_BIT = 1;
  localparam int          STAT_CNT_LSB  = 8;
  // Format select codes.
  localparam logic [1:0]  FMT_OFF  = 2'h0;
  localparam logic [1:0]  FMT_STD  = 2'h1;
  localparam logic [1:0]  FMT_RSV  = 2'h2;
  localparam logic [1:0]  FMT_ONES = 2'h3;
  // Framing modes.
  localparam logic [1:0]  MODE_SF  = 2'h0;
  localparam logic [1:0]  MODE_N   = 2'h1;
  localparam logic [1:0]  MODE_DMX = 2'h2;
  localparam logic [1:0]  MODE_ESF = 2'h3;
  // Data-link alarm patterns and the pattern count that ends an alarm.
  localparam logic [15:0] PAT_STD    = 16'hFF00;
  localparam logic [15:0] PAT_ONES   = 16'hFFFF;
  localparam logic [7:0]  PAT_TARGET = 8'hFF;
  // Spacing between alarms: one second at the 40 MHz clock.
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          HOLD_S      = 1;
  localparam int          HOLD_CYCLES = HOLD_S * CLK_HZ;
  localparam int          HOLD_W      = 26;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_HOLD} tyag_state_e;
endpackage : tyag_pkg

//--- sim/tyag_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// Framer stand-in: one line bit every other cycle, slot flags from a bit count.
module tyag_line_model (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tx_bit_valid,
  output logic      tx_data_in,
  output logic      tx_ds0_bit2,
  output logic      tx_ybit_slot,
  output logic      tx_dl_slot
);
  logic [1:0] bc;
  // Between bits the data line toggles, so a stale bit is never taken for a fresh one.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_bit_valid, tx_data_in, tx_ds0_bit2, tx_ybit_slot, tx_dl_slot, bc} <= '0;
    end else begin
      tx_bit_valid <= ~tx_bit_valid;
      tx_data_in   <= tx_bit_valid ? ~tx_data_in : 1'($urandom);
      tx_ds0_bit2  <= !tx_bit_valid && bc == 2'h1;
      tx_ybit_slot <= !tx_bit_valid && bc == 2'h2;
      tx_dl_slot   <= !tx_bit_valid && bc[0];
      bc           <= bc + 2'(tx_bit_valid);
    end
  end
endmodule : tyag_line_model
`default_nettype wire

//--- sim/tyag_yellow_gen_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tyag_yellow_gen_tb_top;
  import tyag_pkg::*;
  localparam int HOLD = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        v, d, s2, sy, sdl, vo, dout, act, exp_d, exp_v, act_p, on;
  logic [1:0]  mode, fmt;
  logic [15:0] pat;
  int          fails, compares, idx, n, i0;

  tyag_yellow_gen #(.HOLDOFF_CYCLES(HOLD)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_valid(v), .tx_data_in(d), .tx_ds0_bit2(s2), .tx_ybit_slot(sy), .tx_dl_slot(sdl),
    .tx_bit_valid_out(vo), .tx_data_out(dout), .alarm_active(act));
  tyag_line_model i_line (.pclk(pclk), .presetn(presetn), .tx_bit_valid(v), .tx_data_in(d),
    .tx_ds0_bit2(s2), .tx_ybit_slot(sy), .tx_dl_slot(sdl));

  task automatic close_out();
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // The request stands until pready is sampled high; data and error are taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin fails++; close_out(); end
    r = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in this time step.
    @(posedge pclk);
  endtask : apb

  // Low nibble is random: those bits are unused and must read back as zero.
  task automatic ctl(input logic e, input logic en, input logic [1:0] f);
    apb(1'b1, ADDR_CTRL, {24'h0, e, en, f, 4'($urandom)});
    fmt <= f;
  endtask : ctl

  task automatic wact(input logic w, input int b);
    n = 0;
    while (act !== w && n < b) begin @(posedge pclk); n++; end
    if (act !== w) begin fails++; $display("unexpected alarm_active: expected %b seen %b", w, act); close_out(); end
  endtask : wact

  // Reference model of the outgoing stream, one cycle behind the line side.
  always @(posedge pclk) begin
    if (on) chk("tx_data_out", exp_d, dout);
    if (on) chk("tx_bit_valid_out", exp_v, vo);
    exp_v = v; exp_d = d; pat = (fmt == FMT_STD) ? PAT_STD : PAT_ONES;
    if (act === 1'b1) begin
      if (!act_p) idx = 0;
      if ((mode < MODE_DMX && s2) || (mode == MODE_DMX && sy)) exp_d = 1'b0;
      if (mode == MODE_ESF && sdl) begin exp_d = pat[15 - idx % 16]; idx++; end
    end
    act_p = act;
  end

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, on, mode, fmt, act_p, exp_d, exp_v} = '0;
    void'($urandom(32'hAE4C51ED));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    on = 1'b1;
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, (i == 0) ? ADDR_CTRL : (i == 1) ? ADDR_FRAME : (i == 2) ? ADDR_STAT : 12'h00C, 32'h0);
      chk("reg_read", 32'h0, r);
      chk("pslverr", 32'(i == 3), 32'(err));
    end
    $display("test registers done");
    ctl(1'b1, 1'b1, FMT_OFF); repeat (40) @(posedge pclk); chk("alarm_active", 32'h0, 32'(act));
    ctl(1'b0, 1'b1, FMT_STD); repeat (40) @(posedge pclk); chk("alarm_active", 32'h0, 32'(act));
    apb(1'b0, ADDR_CTRL, 32'h0); chk("ctrl", 32'h50, r);
    ctl(1'b0, 1'b0, FMT_OFF);
    $display("test disabled done");
    for (int m = 0; m < 3; m++) begin
      for (int f = 1; f < 4; f += 2) begin
        apb(1'b1, ADDR_FRAME, 32'(m)); mode <= 2'(m);
        ctl(1'b1, 1'b1, 2'(f)); wact(1'b1, 5); repeat (30) @(posedge pclk);
        ctl(1'b1, 1'b0, 2'(f)); wact(1'b0, 5); ctl(1'b1, 1'b1, 2'(f));
        wact(1'b1, HOLD + 10); chk("holdoff", 32'h1, 32'(n >= HOLD - 4));
        ctl(1'b1, 1'b0, 2'(f)); wact(1'b0, 5); repeat (HOLD + 2) @(posedge pclk);
      end
    end
    $display("test framed modes done");
    apb(1'b1, ADDR_FRAME, 32'(MODE_ESF)); mode <= MODE_ESF;
    for (int f = 1; f < 4; f += 2) begin
      ctl(1'b1, 1'b1, 2'(f)); wact(1'b1, 5); ctl(1'b1, 1'b0, 2'(f));
      wact(1'b0, 20000); chk("dl_slots", 32'd4080, 32'(idx));
      repeat (HOLD + 2) @(posedge pclk);
    end
    ctl(1'b1, 1'b1, FMT_ONES); wact(1'b1, 5); repeat (16440) @(posedge pclk);
    chk("alarm_active", 32'h1, 32'(act));
    apb(1'b0, ADDR_STAT, 32'h0); chk("status", 32'h0000_FF01, r);
    ctl(1'b1, 1'b0, FMT_ONES); wact(1'b0, 10);
    apb(1'b0, ADDR_STAT, 32'h0); chk("status", 32'h0000_FF02, r);
    repeat (HOLD + 2) @(posedge pclk);
    ctl(1'b1, 1'b1, FMT_STD); wact(1'b1, 5); repeat (640) @(posedge pclk);
    ctl(1'b1, 1'b0, FMT_STD); ctl(1'b1, 1'b1, FMT_STD); i0 = idx; ctl(1'b1, 1'b0, FMT_STD);
    wact(1'b0, 20000); chk("retrigger", 32'h1, 32'(idx - i0 >= 4064 && idx - i0 <= 4081));
    $display("test data link done");
    close_out();
  end
endmodule : tyag_yellow_gen_tb_top
`default_nettype wire
